// *** pkg/mdec_defines.svh ***
// constants for the opcode decoder block
`ifndef MDEC_DEFINES_SVH
`define MDEC_DEFINES_SVH
`define MDEC_CLK_MHZ       100
`define MDEC_ADDR_CTRL     12'h000
`define MDEC_ADDR_OPCODE   12'h004
`define MDEC_ADDR_INFO     12'h008
`define MDEC_ADDR_FLAGS    12'h00C
`define MDEC_ADDR_STATUS   12'h010
`define MDEC_CTRL_GO       0
`define MDEC_CTRL_IRQPIN   1
`define MDEC_FLG_H         4
`define MDEC_FLG_I         3
`define MDEC_FLG_N         2
`define MDEC_FLG_Z         1
`define MDEC_FLG_C         0
`define MDEC_FLAGS_RESET   5'h08
`endif

// *** pkg/mdec_pkg.sv ***
// types for the opcode decoder block
package mdec_pkg;
    typedef enum logic [4:0] {
        MDEC_K_UNDEF = 5'h01,
        MDEC_K_REGMEM = 5'h02,
        MDEC_K_RMW = 5'h04,
        MDEC_K_BRANCH = 5'h08,
        MDEC_K_BIT = 5'h10,
        MDEC_K_CTRL = 5'h00
    } mdec_kind_e;
    typedef struct packed {
        logic       valid;
        logic [4:0] kind;
        logic [3:0] mode;
        logic [3:0] op;
        logic [1:0] bytes;
        logic [3:0] cycles;
        logic [4:0] fmask;
        logic       wr_back;
    } mdec_info_s;
    typedef enum logic [1:0] {
        MDEC_IDLE = 2'b01,
        MDEC_BUSY = 2'b10
    } mdec_state_e;
endpackage : mdec_pkg

// *** hw/mdec_core.sv ***
// opcode decoder and cycle sequencer with apb register access
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "mdec_defines.svh"
module mdec_core
    import mdec_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        irq_pin,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busy
);
    // bytes/cycles tables for register/memory modes, index = high nibble
    function automatic mdec_info_s decode(input logic [7:0] opc);
        mdec_info_s d;
        logic [3:0] hi;
        logic [3:0] lo;
        logic       st;
        d = '0;
        hi = opc[7:4];
        lo = opc[3:0];
        st = (lo == 4'h7) || (lo == 4'hF);
        d.op = lo;
        d.mode = hi;
        case (hi)
            4'h0, 4'h1: begin
                d.valid = 1'b1;
                d.kind = MDEC_K_BIT;
                d.bytes = hi[0] ? 2'd2 : 2'd3;
                d.cycles = hi[0] ? 4'd7 : 4'd10;
                d.fmask = hi[0] ? 5'h00 : 5'h01;
                d.wr_back = hi[0];
            end
            4'h2: begin
                d.valid = 1'b1;
                d.kind = MDEC_K_BRANCH;
                d.bytes = 2'd2;
                d.cycles = 4'd4;
            end
            4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
                // legal low nibbles 0,3,4,6,7,8,9,A,C,D,F
                d.valid = (lo != 4'h1) && (lo != 4'h2) && (lo != 4'h5)
                          && (lo != 4'hB) && (lo != 4'hE);
                d.kind = MDEC_K_RMW;
                d.wr_back = (lo != 4'hD);
                case (hi)
                    4'h4, 4'h5: begin
                        d.bytes = 2'd1;
                        d.cycles = 4'd4;
                    end
                    4'h3: begin
                        d.bytes = 2'd2;
                        d.cycles = 4'd6;
                    end
                    4'h7: begin
                        d.bytes = 2'd1;
                        d.cycles = 4'd6;
                    end
                    default: begin
                        d.bytes = 2'd2;
                        d.cycles = 4'd7;
                    end
                endcase
                case (lo)
                    4'hA, 4'hC, 4'hD, 4'hF: d.fmask = 5'h06;
                    default: d.fmask = 5'h07;
                endcase
            end
            4'h8, 4'h9: begin
                d.kind = MDEC_K_CTRL;
                d.bytes = 2'd1;
                d.cycles = 4'd2;
                case (opc)
                    8'h80: begin
                        d.valid = 1'b1;
                        d.cycles = 4'd9;
                        d.fmask = 5'h1F;
                    end
                    8'h81: begin
                        d.valid = 1'b1;
                        d.cycles = 4'd6;
                    end
                    8'h83: begin
                        d.valid = 1'b1;
                        d.cycles = 4'd11;
                        d.fmask = 5'h08;
                    end
                    8'h97, 8'h9C, 8'h9D, 8'h9F: d.valid = 1'b1;
                    8'h98, 8'h99: begin
                        d.valid = 1'b1;
                        d.fmask = 5'h01;
                    end
                    8'h9A, 8'h9B: begin
                        d.valid = 1'b1;
                        d.fmask = 5'h08;
                    end
                    default: d.valid = 1'b0;
                endcase
            end
            default: begin
                d.kind = MDEC_K_REGMEM;
                d.valid = !(lo == 4'hC && hi == 4'hA) && !(st && hi == 4'hA)
                          && !(lo == 4'hD && hi == 4'hA && 1'b0);
                case (hi)
                    4'hA: begin
                        d.bytes = 2'd2;
                        d.cycles = 4'd2;
                    end
                    4'hB, 4'hE: begin
                        d.bytes = 2'd2;
                        d.cycles = (hi == 4'hB) ? 4'd4 : 4'd5;
                    end
                    4'hC: begin
                        d.bytes = 2'd3;
                        d.cycles = 4'd5;
                    end
                    4'hF: begin
                        d.bytes = 2'd1;
                        d.cycles = 4'd4;
                    end
                    default: begin
                        d.bytes = 2'd3;
                        d.cycles = 4'd6;
                    end
                endcase
                if (st) begin
                    d.cycles = d.cycles + 4'd1;
                    d.wr_back = 1'b1;
                end
                if (lo == 4'hC) begin
                    d.cycles = d.cycles - 4'd1;
                end
                if (lo == 4'hD) begin
                    d.cycles = d.cycles + 4'd3;
                end
                if (opc == 8'hAD) begin
                    d.bytes = 2'd2;
                    d.cycles = 4'd8;
                    d.kind = MDEC_K_BRANCH;
                end
                case (lo)
                    4'h0, 4'h1, 4'h2, 4'h3: d.fmask = 5'h07;
                    4'h9, 4'hB: d.fmask = 5'h17;
                    4'hC, 4'hD: d.fmask = 5'h00;
                    default: d.fmask = 5'h06;
                endcase
            end
        endcase
        if (!d.valid) begin
            d.kind = MDEC_K_UNDEF;
            d.bytes = 2'd1;
            d.cycles = 4'd2;
            d.fmask = 5'h00;
            d.wr_back = 1'b0;
        end
        return d;
    endfunction : decode

    // branch condition for 2x opcodes, flags and sampled irq level
    function automatic logic cond(input logic [3:0] c, input logic [4:0] f,
                                  input logic irq);
        logic t;
        case (c[3:1])
            3'd0: t = 1'b1;
            3'd1: t = !(f[`MDEC_FLG_C] | f[`MDEC_FLG_Z]);
            3'd2: t = !f[`MDEC_FLG_C];
            3'd3: t = !f[`MDEC_FLG_Z];
            3'd4: t = !f[`MDEC_FLG_H];
            3'd5: t = !f[`MDEC_FLG_N];
            3'd6: t = !f[`MDEC_FLG_I];
            default: t = irq;
        endcase
        return (c[3:1] == 3'd7) ? (c[0] ? t : !t) : (c[0] ? !t : t);
    endfunction : cond

    logic [7:0]  opcode;
    logic [7:0]  offset;
    logic [4:0]  flags;
    logic [3:0]  remain;
    logic [7:0]  taken_cnt;
    logic        irq_meta;
    logic        irq_sync;
    logic        go;
    mdec_state_e state;
    mdec_info_s  info;
    mdec_info_s  cur;
    logic        wr_acc;
    logic        rd_acc;
    logic [7:0]  index_byte;
    logic [8:0]  ix1_addr;

    assign info = decode(opcode);
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    // unsigned sum: a table may run past address 0FF
    assign ix1_addr = {1'b0, offset} + {1'b0, index_byte};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_meta <= 1'b0;
            irq_sync <= 1'b0;
        end else begin
            irq_meta <= irq_pin;
            irq_sync <= irq_meta;
        end
    end

    // opcode and offset byte written by software before a go
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opcode <= 8'h9D;
            offset <= 8'h00;
        end else if (wr_acc && paddr == `MDEC_ADDR_OPCODE && state == MDEC_IDLE) begin
            opcode <= pwdata[7:0];
            offset <= pwdata[15:8];
        end
    end

    // index image travels with the opcode word, refused while busy too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_byte <= 8'h00;
        end else if (wr_acc && paddr == `MDEC_ADDR_OPCODE && state == MDEC_IDLE) begin
            index_byte <= pwdata[23:16];
        end
    end

    assign go = wr_acc && paddr == `MDEC_ADDR_CTRL && pwdata[`MDEC_CTRL_GO];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= MDEC_IDLE;
            remain <= 4'h0;
            cur <= '0;
        end else begin
            case (state)
                MDEC_IDLE: begin
                    if (go) begin
                        state <= MDEC_BUSY;
                        remain <= info.cycles - 4'd1;
                        cur <= info;
                    end
                end
                MDEC_BUSY: begin
                    if (remain == 4'd1) begin
                        state <= MDEC_IDLE;
                    end
                    remain <= remain - 4'd1;
                end
                default: state <= MDEC_IDLE;
            endcase
        end
    end

    // flag effects applied at instruction start; branches leave flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= `MDEC_FLAGS_RESET;
            taken_cnt <= 8'h00;
        end else if (state == MDEC_IDLE && go) begin
            case (opcode)
                8'h99: flags[`MDEC_FLG_C] <= 1'b1;
                8'h98: flags[`MDEC_FLG_C] <= 1'b0;
                8'h9B, 8'h83: flags[`MDEC_FLG_I] <= 1'b1;
                8'h9A: flags[`MDEC_FLG_I] <= 1'b0;
                8'h80: flags <= offset[4:0];
                default: begin
                    if (info.kind == MDEC_K_RMW && opcode[3:0] == 4'hF) begin
                        flags[`MDEC_FLG_N] <= 1'b0;
                        flags[`MDEC_FLG_Z] <= 1'b1;
                    end else if (info.kind == MDEC_K_RMW && opcode[3:0] == 4'h3) begin
                        flags[`MDEC_FLG_C] <= 1'b1;
                    end else if (info.kind == MDEC_K_RMW && opcode[3:0] == 4'h4) begin
                        flags[`MDEC_FLG_N] <= 1'b0;
                    end else if (info.kind == MDEC_K_BIT && !opcode[4]) begin
                        flags[`MDEC_FLG_C] <= offset[opcode[3:1]];
                    end
                    if (opcode[7:4] == 4'h2 && cond(opcode[3:0], flags, irq_sync)) begin
                        taken_cnt <= taken_cnt + 8'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            busy <= 1'b0;
        end else begin
            // a go while busy is ignored, so it must not stretch busy
            busy <= (state == MDEC_BUSY) || (state == MDEC_IDLE && go);
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr > `MDEC_ADDR_STATUS || paddr[1:0] != 2'b00);
            if (rd_acc) begin
                case (paddr)
                    `MDEC_ADDR_OPCODE: prdata <= {7'h00, ix1_addr, offset, opcode};
                    `MDEC_ADDR_INFO:   prdata <= {6'h00, info};
                    `MDEC_ADDR_FLAGS:  prdata <= {27'h0, flags};
                    `MDEC_ADDR_STATUS: prdata <= {taken_cnt, 4'h0, remain,
                                                  7'h00, irq_sync, 6'h00, cur.valid,
                                                  state == MDEC_BUSY};
                    default:           prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : mdec_core

// *** tb/mdec_core_properties.sv ***
// port-level checker for the opcode decoder
`timescale 1ns/10ps
module mdec_core_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        irq_pin,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic go_w;
    assign go_w = psel && penable && pwrite && paddr == 12'h000 && pwdata[0];
    answer_next_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_in_access_a: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside access");
    misalign_err_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    unmapped_err_a: assert property (psel && !penable && paddr > 12'h010 |=> pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (psel && !penable && paddr[1:0] == 2'h0
        && paddr <= 12'h010 |=> !pslverr) else $error("mapped access refused");
    busy_cause_a: assert property ($rose(busy) |-> $past(go_w))
        else $error("busy without start");
    busy_min_a: assert property ($rose(busy) |=> busy)
        else $error("busy shorter than two cycles");
    busy_max_a: assert property ($rose(busy) |-> ##[1:11] !busy)
        else $error("busy longer than eleven cycles");
endmodule : mdec_core_checker

bind mdec_core mdec_core_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .irq_pin(irq_pin), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

// *** tb/mdec_prog_mem.sv ***
// program memory model handing opcode words to the bench
`timescale 1ns/10ps
module mdec_prog_mem (
    input wire logic [4:0]  idx,
    output logic     [15:0] word
);
    // one opcode from each group, index 19 is undefined
    localparam logic [7:0] OPS [21] = '{8'hA6, 8'hB7, 8'hD6, 8'hF7, 8'hE6, 8'hC7,
        8'hBC, 8'hDD, 8'h4C, 8'h3C, 8'h6D, 8'h7F, 8'h21, 8'hAD, 8'h0E, 8'h1F,
        8'h83, 8'h80, 8'h9D, 8'h31, 8'h97};
    assign word = {8'h00, OPS[idx]};
endmodule : mdec_prog_mem

// *** tb/testbench.sv ***
// self-checking bench for the opcode decoder
`timescale 1ns/10ps
module testbench;
    import mdec_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        irq_pin;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic [4:0]  idx;
    logic [15:0] word;
    int          n_errors;
    int          n_checks;
    int          exp_cyc [21] = '{2, 5, 6, 5, 5, 6, 3, 9, 4, 6, 7, 6, 4, 8, 10, 7, 11, 9, 2, 2, 2};
    int          exp_len [21] = '{2, 2, 3, 1, 2, 3, 2, 3, 1, 2, 2, 1, 2, 2, 3, 2, 1, 1, 1, 1, 1};

    mdec_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .irq_pin(irq_pin),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
    mdec_prog_mem mem (.idx(idx), .word(word));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // apb transfer, request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    // start one instruction and count the cycles busy stays high
    task run(input logic [15:0] w, output int n);
        int k;
        k = 0;
        n = 0;
        wr(12'h004, {16'h0000, w});
        wr(12'h000, 32'h0000_0001);
        do begin
            @(posedge pclk);
            k++;
        end while (busy !== 1'b1 && k < 5);
        while (busy === 1'b1 && n < 40) begin
            n++;
            @(posedge pclk);
        end
    endtask : run

    task t_reset;
        logic [31:0] r;
        logic        e;
        apb(1'b0, 12'h00C, 32'h0, r, e);
        chk(r[4:0], 32'h0000_0008);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk(r[7:0], 32'h0000_009D);
        $display("test reset done");
    endtask : t_reset

    task t_decode;
        logic [31:0] r;
        logic        e;
        mdec_info_s  inf;
        int          n;
        for (int i = 0; i < 21; i++) begin
            idx = 5'(i);
            #1;
            run(word, n);
            chk(n, exp_cyc[i]);
            apb(1'b0, 12'h008, 32'h0, r, e);
            inf = mdec_info_s'(r[25:0]);
            chk(inf.bytes, exp_len[i]);
            chk(inf.cycles, exp_cyc[i]);
            chk(inf.valid, i != 19);
        end
        $display("test decode done");
    endtask : t_decode

    // each single-flag step flips the flag it checks, so a dead update shows; 12 and 20 must leave flags alone
    task automatic t_flags;
        logic [15:0] w [14] = '{16'h009B, 16'h009A, 16'h0083, 16'h0099, 16'h0098,
            16'h0043, 16'h1580, 16'h004F, 16'h1F80, 16'h0002, 16'h0203, 16'h0044,
            16'h0012, 16'h0020};
        logic [4:0]  m [14] = '{5'h08, 5'h08, 5'h08, 5'h01, 5'h01, 5'h01, 5'h1F, 5'h06,
            5'h1F, 5'h01, 5'h01, 5'h04, 5'h1F, 5'h1F};
        logic [4:0]  x [14] = '{5'h08, 5'h00, 5'h08, 5'h01, 5'h00, 5'h01, 5'h15, 5'h02,
            5'h1F, 5'h00, 5'h01, 5'h00, 5'h1B, 5'h1B};
        logic [31:0] r;
        logic        e;
        int          n;
        for (int i = 0; i < 14; i++) begin
            run(w[i], n);
            apb(1'b0, 12'h00C, 32'h0, r, e);
            chk(r[4:0] & m[i], x[i]);
        end
        $display("test flags done");
    endtask : t_flags

    // mask is set on entry, so the mask-clear branch is not taken
    task automatic t_branch;
        logic [7:0]  op [6] = '{8'h2E, 8'h2F, 8'h2F, 8'h21, 8'h20, 8'h2C};
        logic        lv [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        logic [7:0]  inc [6] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
        logic [31:0] r;
        logic [7:0]  c0;
        logic        e;
        int          n;
        for (int i = 0; i < 6; i++) begin
            irq_pin <= lv[i];
            repeat (4) @(posedge pclk);
            apb(1'b0, 12'h010, 32'h0, r, e);
            chk(r[8], lv[i]);
            c0 = r[31:24];
            run({8'h00, op[i]}, n);
            apb(1'b0, 12'h010, 32'h0, r, e);
            chk(r[31:24], c0 + inc[i]);
        end
        $display("test branch done");
    endtask : t_branch

    task t_refuse;
        logic [31:0] r;
        logic        e;
        wr(12'h004, 32'h0020_F06C);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk(r[24:16], 32'h0000_0110);
        wr(12'h004, 32'h0000_000E);
        wr(12'h000, 32'h0000_0001);
        wr(12'h004, 32'h0000_009D);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk(r[7:0], 32'h0000_000E);
        apb(1'b0, 12'h014, 32'h0, r, e);
        chk(e, 1'b1);
        apb(1'b0, 12'h002, 32'h0, r, e);
        chk(e, 1'b1);
        apb(1'b1, 12'h010, 32'h0, r, e);
        chk(e, 1'b0);
        $display("test refuse done");
    endtask : t_refuse

    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end

    initial begin
        n_errors = 0;
        n_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        irq_pin = 1'b1;
        idx = 5'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_decode();
        t_flags();
        t_branch();
        t_refuse();
        wrap_up();
    end
endmodule : testbench
